// ---- verilog/programmable_timer_micromachine.sv ----
// Contract
// RULE1 - Micromachine executes timer programs; 30 instruction codes, others flagged illegal.
// RULE2 - 160-word instruction memory, every word carries a parity bit.
// RULE3 - Program-defined 25-bit virtual counters live in instruction control fields.
// RULE4 - 7-bit hardware phase counter extends captures to 32-bit resolution.
// RULE5 - All 32 pins usable as inputs or program-driven outputs.
// RULE6 - Each input pin has its own programmable pulse suppression filter.
// RULE7 - Memory in 4 banks; one word written while another is read.
// RULE8 - Each word is 96 bits: program, control and data fields of 32.
// RULE9 - Source keeps standard capture period at least 2*hr*lr clocks plus 2 ns.
// RULE10 - Source keeps standard high and low phases at least hr*lr clocks plus 2 ns.
// RULE11 - Source keeps measured periods and phases below 2^25*hr*lr clocks minus 2 ns.
// RULE12 - Source keeps enhanced capture period at least hr*lr clocks plus 2 ns.
// RULE13 - Source keeps enhanced high and low phases at least 2*hr clocks plus 2 ns.
// RULE14 - High-res tick divides clock by hires field; loop period by loop field.
// RULE15 - Enhanced capture only on channels 15,20,31 or 12,14,16 by instance.
// RULE16 - 32-bit capture on all first-instance channels; six on the second.
// RULE17 - Memory reachable by transfer unit or DMA through the host port.
// RULE18 - Loopback from outputs to inputs and pin status readback provided.
// RULE19 - Failed parity on any memory read raises an observable error flag.
`timescale 1ns/1ns
module programmable_timer_micromachine
  import timer_pkg::*;
#(
  parameter logic INSTANCE = 1'b0 // 0 first instance, 1 second instance
) (
  input wire logic sys_clk, // Peripheral clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic run, // Start a program pass each loop period
  input wire logic [HR_W-1:0] hires_prescale_field, // hires_factor minus one
  input wire logic [LP_W-1:0] loop_prescale_field, // loop_factor = 2**field
  input wire logic [PINS*FLT_W-1:0] filter_limit, // Per-pin filter setting
  input wire logic loopback_en, // Feed own outputs back to inputs
  input wire logic [PINS-1:0] pin_in, // Pin input levels
  output logic [PINS-1:0] pin_out, // Pin output levels
  output logic [PINS-1:0] pin_oe, // Pin output enables
  output logic [PINS-1:0] pin_status, // Registered pin level readback
  output logic host_ready, // Host port may be used this cycle
  input wire logic host_wr_en, // Host word write
  input wire logic host_rd_en, // Host word read
  input wire logic [ADDR_W-1:0] host_addr, // Host word address
  input wire logic [WORD_W-1:0] host_wr_data, // Host write data
  input wire logic host_par_invert, // Store wrong parity, for diagnostics
  output logic [WORD_W-1:0] host_rd_data, // Host read data
  output logic host_rd_valid, // Host read data valid pulse
  input wire logic flag_clear, // Clear parity and illegal flags
  output logic parity_error, // Sticky parity failure flag
  output logic illegal_op, // Sticky illegal instruction flag
  output logic busy // Program pass in progress
);

  typedef struct packed {
    state_type state;
    logic [ADDR_W-1:0] pc;
    logic [HR_W-1:0] hr_div;
    logic [6:0] lr_div;
    logic [HWCNT_W-1:0] hr_phase;
    logic [VCNT_W-1:0] loop_count;
    logic [PINS-1:0] sampled;
    logic [PINS-1:0] rise_pend;
    logic [PINS-1:0] fall_pend;
    logic [PINS-1:0][HWCNT_W-1:0] rise_stamp;
    logic [PINS-1:0][HWCNT_W-1:0] fall_stamp;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe;
    logic [PINS-1:0] pin_status;
    logic parity_error;
    logic illegal_op;
    logic [WORD_W-1:0] host_rd_data;
    logic host_rd_valid;
    logic host_rd_wait;
  } top_state_type;

  top_state_type s;
  top_state_type next_s;

  timer_ram_if rbus();

  logic hr_tick;
  logic loop_tick;
  logic loop_start;
  logic [PINS-1:0] raw_level;
  logic [PINS-1:0] filt_level;
  logic [FIELD_W-1:0] prog;
  logic [FIELD_W-1:0] ctrl;
  logic [FIELD_W-1:0] data;
  logic [FIELD_W-1:0] new_ctrl;
  logic [FIELD_W-1:0] new_data;
  logic [OP_W-1:0] op;
  logic [PIN_W-1:0] ch;
  logic [ADDR_W-1:0] nxt;
  logic [VCNT_W-1:0] cnt;
  logic [VCNT_W-1:0] dval;
  logic [VCNT_W-1:0] cnt_wrap;
  logic ev;
  logic [HWCNT_W-1:0] stamp;

  // Enhanced pins look every clock, standard pins only on hires ticks
  function automatic logic sample_due(input int i, input logic tick);
    sample_due = is_enhanced(INSTANCE, i) || tick; // [RULE15]
  endfunction : sample_due

  // Only pins wired to the phase counter get the low stamp bits
  function automatic logic [HWCNT_W-1:0] capture_stamp(input int i,
      input logic [HWCNT_W-1:0] phase);
    capture_stamp = has_cap32(INSTANCE, i) ? phase : '0; // [RULE16]
  endfunction : capture_stamp

  timer_ram u_ram (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .port(rbus.ram)
  );

  pin_filter u_filter (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw(raw_level),
    .limit(filter_limit),
    .level(filt_level)
  );

  // Prescaler ticks; loop ends on the last hires tick of the loop
  // Compared with >= so a lowered field takes effect without a long wrap
  assign hr_tick = (s.hr_div >= hires_prescale_field); // [RULE14]
  assign loop_tick = hr_tick && (s.lr_div >= lr_limit(loop_prescale_field)); // [RULE14]
  assign loop_start = loop_tick && run && (s.state == ST_IDLE);
  // Machine owns the memory while running; host waits on host_ready
  assign host_ready = (s.state == ST_IDLE) && !loop_start; // [RULE17]
  assign busy = (s.state == ST_EXEC);
  // Loopback replaces the pins so self-test needs no external wiring
  assign raw_level = loopback_en ? s.pin_out : pin_in; // [RULE18]

  // Decode of the word returned by the memory
  assign prog = rbus.rd_data[PROG_LSB +: FIELD_W]; // [RULE8]
  assign ctrl = rbus.rd_data[CTRL_LSB +: FIELD_W]; // [RULE8]
  assign data = rbus.rd_data[DATA_LSB +: FIELD_W]; // [RULE8]
  assign op = prog[OP_LSB +: OP_W];
  assign ch = prog[PIN_LSB +: PIN_W];
  assign nxt = prog[NEXT_LSB +: ADDR_W];
  assign cnt = ctrl[VCNT_W-1:0]; // [RULE3]
  assign dval = data[DVAL_LSB +: VCNT_W];
  assign cnt_wrap = (cnt == dval) ? '0 : cnt + 25'h1; // [RULE3]
  assign ev = ctrl[EDGE_BIT] ? s.fall_pend[ch] : s.rise_pend[ch];
  assign stamp = ctrl[EDGE_BIT] ? s.fall_stamp[ch] : s.rise_stamp[ch];

  // Next-state logic: prescalers, host port, program pass, edge capture
  always_comb begin
    next_s = s;
    new_ctrl = ctrl;
    new_data = data;
    next_s.host_rd_valid = 1'b0;
    rbus.wr_en = 1'b0;
    rbus.wr_addr = '0;
    rbus.wr_data = '0;
    rbus.wr_par_invert = 1'b0;
    rbus.rd_en = 1'b0;
    rbus.rd_addr = '0;
    // Clear first so a same-cycle set below wins
    if (flag_clear) begin
      next_s.parity_error = 1'b0;
      next_s.illegal_op = 1'b0;
    end
    next_s.hr_div = hr_tick ? '0 : s.hr_div + 6'h01; // [RULE14]
    if (hr_tick) begin
      next_s.lr_div = loop_tick ? '0 : s.lr_div + 7'h01; // [RULE14]
      next_s.hr_phase = loop_tick ? '0 : s.hr_phase + 7'h01; // [RULE4]
    end
    if (loop_tick) begin
      next_s.loop_count = s.loop_count + 25'h1; // [RULE3]
    end
    next_s.pin_status = raw_level; // [RULE18]
    // Host read answer two cycles after the request
    if (s.host_rd_wait) begin
      next_s.host_rd_wait = 1'b0;
      next_s.host_rd_data = rbus.rd_data;
      next_s.host_rd_valid = 1'b1;
      if (rbus.rd_par_err) begin
        next_s.parity_error = 1'b1; // [RULE19]
      end
    end
    // Host write and read may be taken in the same cycle
    if (host_ready) begin
      rbus.wr_en = host_wr_en; // [RULE17]
      rbus.wr_addr = host_addr;
      rbus.wr_data = host_wr_data;
      rbus.wr_par_invert = host_par_invert;
      if (host_rd_en) begin
        rbus.rd_en = 1'b1;
        rbus.rd_addr = host_addr;
        next_s.host_rd_wait = 1'b1;
      end
    end
    if (loop_start) begin
      rbus.rd_en = 1'b1;
      rbus.rd_addr = '0;
      next_s.pc = '0;
      next_s.state = ST_EXEC;
    end
    case (s.state)
      ST_IDLE: begin
        next_s.state = loop_start ? ST_EXEC : ST_IDLE;
      end
      ST_EXEC: begin
        if (rbus.rd_par_err) begin
          // Corrupt word is neither executed nor written back
          next_s.parity_error = 1'b1; // [RULE19]
        end else begin
          case (op) // [RULE1]
            OP_CNT: begin
              new_ctrl[VCNT_W-1:0] = cnt_wrap; // [RULE3]
            end
            OP_ECMP: begin
              new_ctrl[VCNT_W-1:0] = cnt_wrap;
              next_s.pin_oe[ch] = 1'b1; // [RULE5]
              if (cnt == dval) begin
                next_s.pin_out[ch] = ctrl[ACT_BIT]; // [RULE5]
              end
            end
            OP_PERIOD_COUNT_INSTR: begin
              if (ev) begin
                new_data = {cnt, stamp}; // [RULE4]
                new_ctrl[VCNT_W-1:0] = '0;
              end else begin
                new_ctrl[VCNT_W-1:0] = cnt + 25'h1; // [RULE3]
              end
            end
            OP_WAIT_CAPTURE_INSTR: begin
              if (ev) begin
                new_data = {s.loop_count, stamp}; // [RULE4]
              end
            end
            OP_MOV: begin
              next_s.pin_oe[ch] = 1'b1; // [RULE5]
              next_s.pin_out[ch] = ctrl[ACT_BIT];
            end
            // Codes 6 to 29 are reserved and act as no operation
            default: begin
              if (op >= NUM_OPCODES) begin
                next_s.illegal_op = 1'b1; // [RULE1]
              end
            end
          endcase
          // Consumed captures release their pending edge
          if ((op == OP_PERIOD_COUNT_INSTR || op == OP_WAIT_CAPTURE_INSTR) && ev) begin
            if (ctrl[EDGE_BIT]) begin
              next_s.fall_pend[ch] = 1'b0;
            end else begin
              next_s.rise_pend[ch] = 1'b0;
            end
          end
          // Write back this word while the next one is read
          rbus.wr_en = 1'b1; // [RULE7]
          rbus.wr_addr = s.pc;
          rbus.wr_data = {prog, new_ctrl, new_data}; // [RULE8]
        end
        // Self-loop or out-of-range next ends the pass to avoid same-word hazard
        if (prog[END_BIT] || nxt >= INSTR_WORDS || nxt == s.pc) begin
          next_s.state = ST_IDLE;
        end else begin
          rbus.rd_en = 1'b1; // [RULE7]
          rbus.rd_addr = nxt;
          next_s.pc = nxt;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    // Edge capture after consumption, so a new edge is never lost
    for (int i = 0; i < PINS; i++) begin
      if (sample_due(i, hr_tick) && filt_level[i] != s.sampled[i]) begin // [RULE15]
        next_s.sampled[i] = filt_level[i];
        if (filt_level[i]) begin
          next_s.rise_pend[i] = 1'b1;
          next_s.rise_stamp[i] = capture_stamp(i, s.hr_phase); // [RULE16]
        end else begin
          next_s.fall_pend[i] = 1'b1;
          next_s.fall_stamp[i] = capture_stamp(i, s.hr_phase); // [RULE16]
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flip-flops
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign pin_status = s.pin_status;
  assign host_rd_data = s.host_rd_data;
  assign host_rd_valid = s.host_rd_valid;
  assign parity_error = s.parity_error;
  assign illegal_op = s.illegal_op;

endmodule : programmable_timer_micromachine

// ---- verilog/timer_pkg.sv ----
package timer_pkg;

  // Memory geometry
  localparam int WORD_W = 96;
  localparam int FIELD_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [7:0] INSTR_WORDS = 8'hA0;
  localparam int BANKS = 4;
  localparam int ROWS = 40;

  // Pins, counters, prescalers
  localparam int PINS = 32;
  localparam int VCNT_W = 25;
  localparam int HWCNT_W = 7;
  localparam int HR_W = 6;
  localparam int LP_W = 3;
  localparam int FLT_W = 4;

  // Field positions inside the 96-bit word
  localparam int PROG_LSB = 64;
  localparam int CTRL_LSB = 32;
  localparam int DATA_LSB = 0;
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int PIN_LSB = 8;
  localparam int PIN_W = 5;
  localparam int NEXT_LSB = 16;
  localparam int END_BIT = 24;
  localparam int EDGE_BIT = 25;
  localparam int ACT_BIT = 26;
  localparam int DVAL_LSB = 7;

  // Instruction codes; 30 codes exist, the rest are illegal
  localparam logic [4:0] NUM_OPCODES = 5'h1E;
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_CNT = 5'h01;
  localparam logic [4:0] OP_ECMP = 5'h02;
  localparam logic [4:0] OP_PERIOD_COUNT_INSTR = 5'h03;
  localparam logic [4:0] OP_WAIT_CAPTURE_INSTR = 5'h04;
  localparam logic [4:0] OP_MOV = 5'h05;

  // Channel capability per instance
  localparam logic [31:0] ENH_MASK_0 = 32'h8010_8000;
  localparam logic [31:0] ENH_MASK_1 = 32'h0001_5000;
  localparam logic [31:0] CAP32_MASK_0 = 32'hFFFF_FFFF;
  localparam logic [31:0] CAP32_MASK_1 = 32'h0001_5051;

  typedef enum logic {ST_IDLE, ST_EXEC} state_type;

  function automatic logic word_parity(input logic [WORD_W-1:0] w);
    word_parity = ^w;
  endfunction : word_parity

  function automatic logic is_enhanced(input logic inst, input int ch);
    is_enhanced = inst ? ENH_MASK_1[ch] : ENH_MASK_0[ch];
  endfunction : is_enhanced

  function automatic logic has_cap32(input logic inst, input int ch);
    has_cap32 = inst ? CAP32_MASK_1[ch] : CAP32_MASK_0[ch];
  endfunction : has_cap32

  function automatic logic [6:0] lr_limit(input logic [LP_W-1:0] f);
    lr_limit = 7'((8'h01 << f) - 8'h01);
  endfunction : lr_limit

endpackage : timer_pkg

// ---- verilog/timer_ram_if.sv ----
`timescale 1ns/1ns
interface timer_ram_if;
  import timer_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic wr_par_invert;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  logic rd_par_err;
  modport ram (input wr_en, wr_addr, wr_data, wr_par_invert, rd_en, rd_addr,
    output rd_data, rd_par_err);
  modport ctrl (output wr_en, wr_addr, wr_data, wr_par_invert, rd_en, rd_addr,
    input rd_data, rd_par_err);
endinterface : timer_ram_if

// ---- verilog/timer_ram.sv ----
`timescale 1ns/1ns
module timer_ram
  import timer_pkg::*;
(
  input wire logic sys_clk, // Peripheral clock
  input wire logic resetn, // Async reset, active low
  timer_ram_if.ram port // Write and read port
);

  // Word plus its parity bit, spread over four banks by the low address bits
  logic [WORD_W:0] mem [BANKS][ROWS];
  logic [WORD_W:0] entry;

  assign entry = mem[port.rd_addr[1:0]][port.rd_addr[7:2]];

  // Write side; not reset, the program is loaded before use
  always_ff @(posedge sys_clk) begin
    if (port.wr_en && port.wr_addr < INSTR_WORDS) begin // [RULE7]
      mem[port.wr_addr[1:0]][port.wr_addr[7:2]] <=
        {word_parity(port.wr_data) ^ port.wr_par_invert, port.wr_data}; // [RULE2]
    end
  end

  // Read side runs in the same cycle as a write to another word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port.rd_data <= '0;
      port.rd_par_err <= 1'b0;
    end else if (port.rd_en) begin
      if (port.rd_addr < INSTR_WORDS) begin // [RULE7]
        port.rd_data <= entry[WORD_W-1:0];
        port.rd_par_err <= word_parity(entry[WORD_W-1:0]) != entry[WORD_W]; // [RULE2]
      end else begin
        port.rd_data <= '0;
        port.rd_par_err <= 1'b0;
      end
    end
  end

endmodule : timer_ram

// ---- verilog/pin_filter.sv ----
`timescale 1ns/1ns
module pin_filter
  import timer_pkg::*;
(
  input wire logic sys_clk, // Peripheral clock
  input wire logic resetn, // Async reset, active low
  input wire logic [PINS-1:0] raw, // Unfiltered pin levels
  input wire logic [PINS*FLT_W-1:0] limit, // Per-pin filter length
  output logic [PINS-1:0] level // Filtered levels
);

  typedef struct packed {
    logic [PINS-1:0] level;
    logic [PINS-1:0][FLT_W-1:0] cnt;
  } filt_state_type;

  filt_state_type s;
  filt_state_type next_s;

  // A change must persist limit+1 cycles; shorter pulses are dropped
  always_comb begin
    next_s = s;
    for (int i = 0; i < PINS; i++) begin
      if (raw[i] == s.level[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] >= limit[i*FLT_W +: FLT_W]) begin // [RULE6]
        next_s.level[i] = raw[i];
        next_s.cnt[i] = '0;
      end else begin
        next_s.cnt[i] = s.cnt[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : pin_filter

// ---- test/timer_properties.sv ----
`timescale 1ns/1ns
module timer_properties
  import timer_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic loopback_en, // Loopback select
  input wire logic [PINS-1:0] pin_in, // Pin levels
  input wire logic [PINS-1:0] pin_out, // Driven levels
  input wire logic [PINS-1:0] pin_oe, // Drive enables
  input wire logic [PINS-1:0] pin_status, // Readback
  input wire logic host_ready, // Port free
  input wire logic host_rd_en, // Read request
  input wire logic [ADDR_W-1:0] host_addr, // Word address
  input wire logic [WORD_W-1:0] host_rd_data, // Read data
  input wire logic host_rd_valid, // Read valid
  input wire logic flag_clear, // Flag clear
  input wire logic parity_error, // Parity flag
  input wire logic illegal_op, // Illegal flag
  input wire logic busy // Pass active
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // Host port answers and exclusion
  a_read_answer: assert property (
    host_rd_en && host_ready |-> ##2 host_rd_valid) else $error("read not answered");
  a_valid_cause: assert property (
    host_rd_valid |-> $past(host_rd_en && host_ready, 2)) else $error("stray read valid");
  a_high_addr: assert property (
    host_rd_en && host_ready && host_addr >= INSTR_WORDS |-> ##2 host_rd_data == '0)
    else $error("unmapped read not zero");
  a_busy_port: assert property (busy |-> !host_ready)
    else $error("port open during pass");

  // Sticky flags; a set from the last edge's read or pass wins over clear
  a_flag_hold: assert property (parity_error && !flag_clear |=> parity_error)
    else $error("parity flag dropped");
  a_flag_cause: assert property (
    $rose(parity_error) |-> host_rd_valid || busy || $past(busy))
    else $error("parity flag without read");
  a_flag_clear: assert property (
    flag_clear && host_ready && !host_rd_en && !busy && !$past(host_rd_en) && !$past(busy)
    |=> !parity_error && !illegal_op) else $error("flags not cleared");
  a_illegal_cause: assert property ($rose(illegal_op) |-> busy || $past(busy))
    else $error("illegal flag outside pass");

  // Pins move only under program control; readback one clock late
  a_pin_source: assert property (
    $changed(pin_oe) || $changed(pin_out) |-> busy || $past(busy))
    else $error("pin changed outside pass");
  a_status_pin: assert property (!loopback_en |=> pin_status == $past(pin_in))
    else $error("status not pin level");
  a_status_loop: assert property (loopback_en |=> pin_status == $past(pin_out))
    else $error("status not looped output");
endmodule : timer_properties

bind programmable_timer_micromachine timer_properties u_props (.sys_clk, .resetn,
  .loopback_en, .pin_in, .pin_out, .pin_oe, .pin_status, .host_ready, .host_rd_en,
  .host_addr, .host_rd_data, .host_rd_valid, .flag_clear, .parity_error, .illegal_op, .busy);

// ---- test/pin_source.sv ----
`timescale 1ns/1ns
module pin_source
  import timer_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic en, // Let levels change
  input wire logic [15:0] hold, // Clocks per level, less one
  output logic [PINS-1:0] pin_in // Levels to the timer
);
  logic [31:0] seed = 32'h5A3C_0F96;
  logic [15:0] cnt = 16'h0000;
  initial pin_in = '0;
  // Levels stand hold+1 clocks, so phases and periods clear both capture
  // minimums and stay far below the overflow bound
  always @(posedge sys_clk) begin
    #1;
    if (en && cnt >= hold) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      pin_in = seed;
      cnt = 16'h0000;
    end else begin
      cnt = cnt + 16'h0001;
    end
  end
endmodule : pin_source

// ---- test/tb_programmable_timer_micromachine.sv ----
`timescale 1ns/1ns
module tb_programmable_timer_micromachine;
  import timer_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic [HR_W-1:0] hr_f = '0;
  logic [LP_W-1:0] lp_f = '0;
  logic [PINS*FLT_W-1:0] filt = '0;
  logic loopback_en = 1'b0;
  logic src_en = 1'b0;
  logic [PINS-1:0] pin_in, pin_out, pin_oe, pin_status;
  logic host_ready, host_rd_valid, parity_error, illegal_op, busy;
  logic host_wr_en = 1'b0, host_rd_en = 1'b0, host_par_invert = 1'b0, flag_clear = 1'b0;
  logic [ADDR_W-1:0] host_addr = '0;
  logic [WORD_W-1:0] host_wr_data = '0, host_rd_data;
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] mem [0:3];
  logic [ADDR_W-1:0] at [0:3] = '{8'h01, 8'h27, 8'h28, 8'h9F};
  logic [31:0] rnd = 32'hD4D1973C;
  logic busy_d = 1'b0;
  int n_fail = 0, cmp_count = 0, npass = 0;
  time t_last = 0, t_gap = 0;

  always #5 sys_clk = ~sys_clk;

  programmable_timer_micromachine #(.INSTANCE(1'b0)) uut (.sys_clk, .resetn, .run,
    .hires_prescale_field(hr_f), .loop_prescale_field(lp_f), .filter_limit(filt),
    .loopback_en, .pin_in, .pin_out, .pin_oe, .pin_status, .host_ready, .host_wr_en,
    .host_rd_en, .host_addr, .host_wr_data, .host_par_invert, .host_rd_data,
    .host_rd_valid, .flag_clear, .parity_error, .illegal_op, .busy);
  pin_source src (.sys_clk, .en(src_en), .hold(16'h0019), .pin_in);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction : xs
  function automatic logic [WORD_W-1:0] rw();
    rnd = xs(rnd);
    rw[31:0] = rnd;
    rnd = xs(rnd);
    rw[63:32] = rnd;
    rnd = xs(rnd);
    rw[95:64] = rnd;
  endfunction : rw
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk) #1;
  endtask : step
  // Request held until an edge sees the port free; caller lowers it
  task automatic host(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [WORD_W-1:0] d, input logic inv);
    int n;
    n = 0;
    host_wr_en = wr;
    host_rd_en = !wr;
    host_addr = a;
    host_wr_data = d;
    host_par_invert = inv;
    while (host_ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    if (n == 50) begin
      n_fail++;
      results();
    end
    step(1);
  endtask : host
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] want);
    exp_q.push_back(want);
    host(1'b0, a, '0, 1'b0);
  endtask : rd
  task automatic quiet();
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
  endtask : quiet
  task automatic pulse_clear();
    flag_clear = 1'b1;
    step(1);
    flag_clear = 1'b0;
    step(1);
  endtask : pulse_clear
  // Passes run for a while, then the bench waits for idle under a bound
  task automatic pass_run(input int n);
    int k;
    k = 0;
    run = 1'b1;
    step(n);
    run = 1'b0;
    while (busy !== 1'b0 && k < 100) begin
      step(1);
      k++;
    end
    if (k == 100) begin
      n_fail++;
      results();
    end
    step(2);
  endtask : pass_run

  // Read results and pass starts are seen at the falling edge, settled
  always @(negedge sys_clk) begin
    if (host_rd_valid === 1'b1 && exp_q.size() == 0)
      check(host_rd_valid, 1'b0);
    else if (host_rd_valid === 1'b1)
      check(host_rd_data, exp_q.pop_front());
    if (busy === 1'b1 && busy_d !== 1'b1) begin
      npass++;
      t_gap = $time - t_last;
      t_last = $time;
    end
    busy_d <= busy;
  end

  initial begin
    int i;
    filt = {rw(), rnd};
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    src_en = 1'b1;
    // Bank edges, back-to-back, and the unmapped address
    for (i = 0; i < 4; i++) begin
      mem[i] = rw();
      host(1'b1, at[i], mem[i], 1'b0);
    end
    host(1'b1, 8'hA0, rw(), 1'b0);
    for (i = 3; i >= 0; i--) rd(at[i], mem[i]);
    rd(8'hA0, '0);
    quiet();
    step(2);
    check(parity_error, 1'b0);
    $display("memory test done");
    host(1'b1, 8'h28, mem[2], 1'b1);
    rd(8'h28, mem[2]);
    quiet();
    step(2);
    check(parity_error, 1'b1);
    pulse_clear();
    check(parity_error, 1'b0);
    $display("parity test done");
    // One drive word on pin 5, level high, end bit set
    host(1'b1, 8'h00, {32'h0100_0505, 32'h0400_0000, 32'h0000_0000}, 1'b0);
    quiet();
    hr_f = 6'h01;
    pass_run(20);
    check(pin_oe, 32'h0000_0020);
    check(pin_out, 32'h0000_0020);
    loopback_en = 1'b1;
    step(2);
    check(pin_status, 32'h0000_0020);
    loopback_en = 1'b0;
    $display("output test done");
    host(1'b1, 8'h00, {32'h0100_001E, 64'h0}, 1'b0);
    quiet();
    pass_run(10);
    check(illegal_op, 1'b1);
    pulse_clear();
    check(illegal_op, 1'b0);
    $display("illegal test done");
    // Counter wraps after 3; loop period is (field+1)*2**loop field clocks
    for (i = 1; i < 4; i++) begin
      host(1'b1, 8'h00, {32'h0100_0001, 32'h0, 32'h0000_0180}, 1'b0);
      quiet();
      hr_f = 6'(i % 3);
      lp_f = 3'(i);
      npass = 0;
      pass_run(100);
      check(96'(t_gap / 10), 96'((i % 3 + 1) << i));
      rd(8'h00, {32'h0100_0001, 7'h00, 25'(npass % 4), 32'h0000_0180});
      quiet();
      step(3);
    end
    $display("counter test done");
    // Compare drives pin 6 at count 2; capture on an edge-free pin only counts
    loopback_en = 1'b1;
    host(1'b1, 8'h00, {32'h0100_0602, 32'h0400_0000, 32'h0000_0100}, 1'b0);
    quiet();
    pass_run(100);
    check(pin_out & pin_oe, 32'h0000_0060);
    // First run flushes edges left pending from before loopback
    for (i = 0; i < 2; i++) begin
      host(1'b1, 8'h00, {32'h0100_0003, 64'h180}, 1'b0);
      quiet();
      npass = 0;
      pass_run(100);
    end
    rd(8'h00, {32'h0100_0003, 7'h00, 25'(npass), 32'h0000_0180});
    quiet();
    step(3);
    loopback_en = 1'b0;
    $display("compare and capture test done");
    check(96'(exp_q.size()), 96'h0);
    results();
  end
endmodule : tb_programmable_timer_micromachine
